/* verilog/board_interrupt_aggregator.sv */
// board interrupt aggregator: apb registers, flags, enables, request line
// assumes apb master on pclk; source inputs asynchronous and synchronised here
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module board_interrupt_aggregator (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        src_buttons,
  input  wire logic        src_switch_bank,
  input  wire logic        src_stick,
  input  wire logic        src_monitor_button,
  input  wire logic        src_network,
  output logic             host_irq_line,
  output logic             irq
);
  localparam int unsigned N = irq_agg_pkg::NUM_SRC;

  irq_agg_pkg::apb_req_t req;
  logic [N-1:0]  raw, evt, any_edge;
  logic [15:0]   enable_q, enable_d, flags_q, flags_d;
  logic [31:0]   prdata_q, prdata_d;
  logic [1:0]    st_q, st_d, msk_q, msk_d;
  logic          line_q, line_d, err_q, err_d;
  logic          access, wr_acc, rd_acc, hit, pending;
  logic          ack_q, ack_d, preload;

  function automatic logic [15:0] src_bits(input logic [31:0] v);
    src_bits = v[15:0] & irq_agg_pkg::SRC_MASK;
  endfunction : src_bits

  assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};

  // source inputs in bit order
  always_comb begin
    raw = '0;
    raw[irq_agg_pkg::BIT_BUTTONS]        = src_buttons;
    raw[irq_agg_pkg::BIT_SWITCH_BANK]    = src_switch_bank;
    raw[irq_agg_pkg::BIT_STICK]          = src_stick;
    raw[irq_agg_pkg::BIT_MONITOR_BUTTON] = src_monitor_button;
    raw[irq_agg_pkg::BIT_NETWORK]        = src_network;
    any_edge = '0;
    any_edge[irq_agg_pkg::BIT_BUTTONS]        = 1'b1;
    any_edge[irq_agg_pkg::BIT_SWITCH_BANK]    = 1'b1;
    any_edge[irq_agg_pkg::BIT_STICK]          = 1'b1;
    any_edge[irq_agg_pkg::BIT_MONITOR_BUTTON] = 1'b1;
  end

  change_detect #(.W(N)) u_detect (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .raw_in      (raw),
    .any_edge    (any_edge),
    .event_pulse (evt)
  );

  // one wait state: the first access cycle loads prdata, the second completes,
  // so registered read data already stands at the edge where pready is high
  assign preload = req.sel & req.en & clk_en & ~ack_q;
  assign access  = req.sel & req.en & clk_en & ack_q;
  assign wr_acc  = access & req.wr;
  assign rd_acc  = access & ~req.wr;
  assign ack_d   = clk_en ? (req.sel & req.en & ~ack_q) : ack_q;
  assign pready  = ack_q;
  assign pslverr = 1'b0;
  assign prdata  = prdata_q;

  always_comb begin
    case (req.addr)
      irq_agg_pkg::OFS_ENABLE, irq_agg_pkg::OFS_ENABLE_SET, irq_agg_pkg::OFS_ENABLE_CLR,
      irq_agg_pkg::OFS_FLAGS, irq_agg_pkg::OFS_FLAGS_CLR, irq_agg_pkg::OFS_IRQ_STATUS,
      irq_agg_pkg::OFS_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // enable and flag registers; an event in the clear cycle survives
  always_comb begin
    enable_d = enable_q;
    flags_d  = flags_q;
    if (wr_acc) begin
      case (req.addr)
        irq_agg_pkg::OFS_ENABLE:     enable_d = src_bits(req.wdata);
        irq_agg_pkg::OFS_ENABLE_SET: enable_d = enable_q | src_bits(req.wdata);
        irq_agg_pkg::OFS_ENABLE_CLR: enable_d = enable_q & ~src_bits(req.wdata);
        irq_agg_pkg::OFS_FLAGS, irq_agg_pkg::OFS_FLAGS_CLR:
          flags_d = flags_q & ~src_bits(req.wdata);
        default: ;
      endcase
    end
    flags_d = flags_d | {{(16-N){1'b0}}, evt};
  end

  // request level: low while an enabled flag is set
  always_comb begin
    pending = |(flags_q & enable_q);
    line_d  = clk_en ? ~pending : line_q;
  end

  // sticky bus status, cleared by reading it; set beats clear
  always_comb begin
    err_d = access & ~hit;
    st_d  = st_q;
    // clear only what the read returned; a bit set after the snapshot survives
    if (rd_acc && req.addr == irq_agg_pkg::OFS_IRQ_STATUS) st_d = st_q & ~prdata_q[1:0];
    if (line_q && !line_d) st_d[irq_agg_pkg::EVT_REQ_FALL] = 1'b1;
    if (err_d) st_d[irq_agg_pkg::EVT_BAD_ADDR] = 1'b1;
    msk_d = msk_q;
    if (wr_acc && req.addr == irq_agg_pkg::OFS_IRQ_MASK) msk_d = req.wdata[1:0];
  end

  // read mux; reserved and unmapped read as zero
  always_comb begin
    prdata_d = prdata_q;
    if (preload && !req.wr) begin
      case (req.addr)
        irq_agg_pkg::OFS_ENABLE, irq_agg_pkg::OFS_ENABLE_SET,
        irq_agg_pkg::OFS_ENABLE_CLR: prdata_d = {16'h0000, enable_q};
        irq_agg_pkg::OFS_FLAGS, irq_agg_pkg::OFS_FLAGS_CLR: prdata_d = {16'h0000, flags_q};
        irq_agg_pkg::OFS_IRQ_STATUS: prdata_d = {30'h0, st_q};
        irq_agg_pkg::OFS_IRQ_MASK:   prdata_d = {30'h0, msk_q};
        default:                     prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= irq_agg_pkg::ENABLE_RESET;
      flags_q  <= irq_agg_pkg::FLAGS_RESET;
      prdata_q <= 32'h00000000;
      st_q     <= 2'h0;
      msk_q    <= irq_agg_pkg::EVT_MASK_RESET;
      line_q   <= 1'b1;
      err_q    <= 1'b0;
      ack_q    <= 1'b0;
    end else if (clk_en) begin
      ack_q    <= ack_d;
      enable_q <= enable_d;
      flags_q  <= flags_d;
      prdata_q <= prdata_d;
      st_q     <= st_d;
      msk_q    <= msk_d;
      line_q   <= line_d;
      err_q    <= err_d;
    end
  end

  assign host_irq_line = line_q;
  assign irq           = |(st_q & msk_q);

  // read data is loaded one cycle ahead of pready, so it stands at the completing edge

  a_line_follows: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> host_irq_line == !$past(pending)) else $error("request line wrong");
  a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && (flags_q & enable_q) == 16'h0000) |=> host_irq_line) else $error("disabled source drove line");
  a_flags_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !wr_acc) |=> ((flags_q & $past(flags_q)) == $past(flags_q))) else $error("flag lost");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    flags_q[15:5] == 11'h000 && enable_q[15:5] == 11'h000) else $error("reserved bit set");
  a_clear_exact: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && req.addr == irq_agg_pkg::OFS_FLAGS_CLR) |=>
      flags_q == (($past(flags_q) & ~src_bits($past(req.wdata))) | $past({11'h000, evt}))) else $error("clear wrong");
  a_enable_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && req.addr == irq_agg_pkg::OFS_ENABLE_SET) |=>
      enable_q == ($past(enable_q) | src_bits($past(req.wdata)))) else $error("enable set wrong");
  a_enable_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && req.addr == irq_agg_pkg::OFS_ENABLE_CLR) |=>
      enable_q == ($past(enable_q) & ~src_bits($past(req.wdata)))) else $error("enable clear wrong");
  a_event_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && evt[irq_agg_pkg::BIT_NETWORK]) |=> flags_q[irq_agg_pkg::BIT_NETWORK]) else $error("event not latched");
  a_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && req.addr == irq_agg_pkg::OFS_FLAGS) |-> prdata[15:0] == $past(flags_q)) else $error("flag read wrong");
  a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && req.addr == irq_agg_pkg::OFS_IRQ_STATUS) |-> prdata[1:0] == $past(st_q)) else $error("status read wrong");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && pready) |=> !pready) else $error("ready held too long");
  a_fall_status: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && $fell(host_irq_line)) |-> st_q[irq_agg_pkg::EVT_REQ_FALL]) else $error("fall not recorded");

  c_fall: cover property (@(posedge pclk) disable iff (!presetn) $fell(host_irq_line));
  c_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(host_irq_line));
  c_clear_race: cover property (@(posedge pclk) disable iff (!presetn)
    wr_acc && req.addr == irq_agg_pkg::OFS_FLAGS_CLR && evt != '0);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule : board_interrupt_aggregator
`default_nettype wire

/* verilog/irq_agg_pkg.sv */
// constants and carrier types for the board interrupt aggregator
// assumes an apb slave on pclk with 32-bit data and word-aligned registers
// How it works
// - all source events merge onto one request line toward the host
// - a source drives the request only while its enable bit is set
// - the request signals an interrupt by a falling edge, which the host watches for
// - a readable flag register tells which source caused the interrupt
// - the host clears serviced flags and exactly the named mask bits clear
// - bit 0 buttons, bit 1 switch bank, bit 2 stick, bit 3 monitor button, bit 4 network
// - enable sets the masked enable bits, disable clears them, others keep their value
// - button-type sources flag on every change of their input, press or release
package irq_agg_pkg;
  localparam int unsigned NUM_SRC = 5;
  localparam int unsigned REG_W   = 16;
  // source bit positions
  localparam int unsigned BIT_BUTTONS        = 0;
  localparam int unsigned BIT_SWITCH_BANK    = 1;
  localparam int unsigned BIT_STICK          = 2;
  localparam int unsigned BIT_MONITOR_BUTTON = 3;
  localparam int unsigned BIT_NETWORK        = 4;
  // byte offsets
  localparam logic [7:0] OFS_ENABLE     = 8'h00;
  localparam logic [7:0] OFS_ENABLE_SET = 8'h04;
  localparam logic [7:0] OFS_ENABLE_CLR = 8'h08;
  localparam logic [7:0] OFS_FLAGS      = 8'h0C;
  localparam logic [7:0] OFS_FLAGS_CLR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_RESET  = 16'h0000;
  localparam logic [15:0] SRC_MASK     = 16'h001F;
  // bus event status bits
  localparam int unsigned EVT_W         = 2;
  localparam int unsigned EVT_REQ_FALL  = 0;
  localparam int unsigned EVT_BAD_ADDR  = 1;
  localparam logic [1:0]  EVT_MASK_RESET = 2'h0;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } apb_req_t;
endpackage : irq_agg_pkg

/* verilog/change_detect.sv */
// per-source synchroniser and change detector
// assumes raw board inputs asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module change_detect #(
  parameter int unsigned W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] raw_in,
  input  wire logic [W-1:0] any_edge,
  output logic      [W-1:0] event_pulse
);
  logic [W-1:0] s1_q, s1_d, s2_q, s2_d, last_q, last_d;

  // two-stage sync; s1 feeds only s2
  always_comb begin
    s1_d   = clk_en ? raw_in : s1_q;
    s2_d   = clk_en ? s1_q : s2_q;
    last_d = clk_en ? s2_q : last_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= '0;
      s2_q   <= '0;
      last_q <= '0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      last_q <= last_d;
    end
  end

  // sources with their any_edge bit set flag on both edges; others on a rising edge only
  assign event_pulse = clk_en ? ((s2_q ^ last_q) & any_edge) | (s2_q & ~last_q & ~any_edge) : '0;
endmodule : change_detect
`default_nettype wire

/* testbench/host_model.sv */
// host side of the request line: pulled-up input, falling-edge sense
// assumes host_irq_line driven by the aggregator in the pclk domain
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       host_irq_line,
  output logic      [7:0] n_falls
);
  logic pin_q; // sensed pin level
  // undriven or unknown line reads high through the pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q   <= 1'b1;
      n_falls <= 8'h00;
    end else begin
      pin_q <= (host_irq_line === 1'b0) ? 1'b0 : 1'b1;
      if (pin_q && host_irq_line === 1'b0) begin
        n_falls <= n_falls + 8'h01;
      end
    end
  end
endmodule : host_model
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench: apb host software plus board source stimulus
// assumes pready answers within 16 cycles and prdata holds after a read
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [4:0]  src     = 5'h00;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        host_irq_line;
  logic        irq;
  logic [7:0]  n_falls;
  int          n_errors    = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  always #4 pclk = ~pclk;
  board_interrupt_aggregator uut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_buttons(src[0]), .src_switch_bank(src[1]),
    .src_stick(src[2]), .src_monitor_button(src[3]), .src_network(src[4]), .host_irq_line, .irq);
  host_model host (.pclk, .presetn, .host_irq_line, .n_falls);
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; read data taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) begin
      n_errors++;
      $display("unexpected at %0t: no pready", $time);
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk
  // sync, detect, flag and line stages take four edges
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask : settle
  // hang guard: the sequence needs well under 2000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(irq_agg_pkg::OFS_ENABLE, {16'h0, irq_agg_pkg::ENABLE_RESET});
    rd_chk(irq_agg_pkg::OFS_FLAGS, {16'h0, irq_agg_pkg::FLAGS_RESET});
    check(host_irq_line, 1'b1);
    apb(1'b1, irq_agg_pkg::OFS_ENABLE_CLR, 32'hFFFF);
    apb(1'b1, irq_agg_pkg::OFS_FLAGS_CLR, 32'hFFFF);
    apb(1'b1, irq_agg_pkg::OFS_IRQ_MASK, 32'h1);
    // disabled source still latches but keeps the line high
    src[2] <= 1'b1;
    settle();
    rd_chk(irq_agg_pkg::OFS_FLAGS, 32'h4);
    check(host_irq_line, 1'b1);
    apb(1'b1, irq_agg_pkg::OFS_ENABLE_SET, 32'hFFFF_0005);
    rd_chk(irq_agg_pkg::OFS_ENABLE, 32'h5);
    check(host_irq_line, 1'b0);
    check(n_falls, 8'h01);
    check(irq, 1'b1);
    rd_chk(irq_agg_pkg::OFS_IRQ_STATUS, 32'h1);
    check(irq, 1'b0);
    apb(1'b1, irq_agg_pkg::OFS_FLAGS_CLR, 32'h4);
    settle();
    check(host_irq_line, 1'b1);
    apb(1'b1, irq_agg_pkg::OFS_ENABLE_CLR, 32'h1);
    rd_chk(irq_agg_pkg::OFS_ENABLE, 32'h4);
    // each source toggles once: stick releases, network rises
    for (int i = 0; i < 5; i++) begin
      src[i] <= ~src[i];
      settle();
      rd_chk(irq_agg_pkg::OFS_FLAGS, 32'h1 << i);
      apb(1'b1, irq_agg_pkg::OFS_FLAGS, 32'h1 << i);
      rd_chk(irq_agg_pkg::OFS_FLAGS, 32'h0);
    end
    check(n_falls, 8'h02);
    rd_chk(8'h40, 32'h0);
    rd_chk(irq_agg_pkg::OFS_IRQ_STATUS, 32'h3);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
